/* design/switch_partition_strap_config.sv */
// partition strap decode, management port control and link release gating
//
// Notes on behaviour
// - management strap low/float enables selected management port in partition mode
// - decoded port loads active management field
// - control register sets active and redundant ports
// - promote redundant port on authorised write
// - strap low in partition mode: only management port trains
// - initiate bit releases links; via I2C only when its strap set the hold
// - strap floating: all train after EEPROM load
// - I2C strap low holds links until initiate
// - shared pin is slot power good in base
// - partition count strap latched, shown read-only
// - modes 4-7 enable one to three partitions
// - modes 8-11 enable four to six partitions
// - partition enables shown one bit per partition
// - upstream straps decode to five-bit port number
// - straps sampled at reset as default configuration
`timescale 1ns/1ns
module switch_partition_strap_config #(
    parameter int NUM_PORTS = 20
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire strap_cfg_pkg::trit_t i_function_select_strap [3],
    input wire strap_cfg_pkg::trit_t i_upstream_select_strap [3],
    input wire strap_cfg_pkg::trit_t i_management_enable_strap,
    input wire strap_cfg_pkg::trit_t i_partition_count_strap,
    input wire strap_cfg_pkg::trit_t i_i2c_cfg_strap_n,
    input wire logic i_eeprom_done,
    input wire strap_cfg_pkg::reg_req_s i_reg_req,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_ack,
    output logic [NUM_PORTS-1:0] o_link_train_en,
    output logic [5:0] o_partition_enable_bits,
    output logic o_partition_count_strap,
    output logic o_slot_a_power_good,
    output logic [4:0] o_mgmt_port
);
    typedef enum {ST_SAMPLE, ST_EEPROM, ST_HOLD, ST_RUN} link_state_e;

    localparam int NS = 9;

    logic [2*NS-1:0] pins, live, capd;
    logic cap_pulse;
    strap_cfg_pkg::trit_t cfsel [3];
    strap_cfg_pkg::trit_t cusel [3];
    strap_cfg_pkg::strap_cfg_s dec, cfg_r, cfg_nxt;

    logic [4:0] act_r, act_nxt, red_r, red_nxt;
    logic act_en_r, act_en_nxt, red_en_r, red_en_nxt;
    logic [5:0] part_r, part_nxt;
    logic init_r, init_nxt, valid_r, valid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    link_state_e st_r, st_nxt;
    logic [NUM_PORTS-1:0] link_r, link_nxt;
    logic pg_r, pg_nxt;
    logic wr_mgmt, wr_part, wr_rel, promote_ok, hold_mgmt;

    function automatic logic [NUM_PORTS-1:0] port_onehot(input logic [4:0] p);
        port_onehot = {{(NUM_PORTS-1){1'b0}}, 1'b1} << p;
    endfunction

    // ==========
    // strap sampling and decode
    assign pins = {i_i2c_cfg_strap_n, i_management_enable_strap, i_partition_count_strap,
                   i_upstream_select_strap[2], i_upstream_select_strap[1], i_upstream_select_strap[0],
                   i_function_select_strap[2], i_function_select_strap[1], i_function_select_strap[0]};

    tristate_strap_sampler #(.N(NS)) u_sampler (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_pin(pins),
        .o_live(live),
        .o_captured(capd),
        .o_capture_pulse(cap_pulse)
    );

    generate
        for (genvar g = 0; g < 3; g++)
        begin : g_trit
            assign cfsel[g] = capd[2*g +: 2];
            assign cusel[g] = capd[6 + 2*g +: 2];
        end
    endgenerate

    partition_strap_decoder u_decoder (
        .i_fsel(cfsel),
        .i_usel(cusel),
        .i_mgmt(capd[14 +: 2]),
        .i_part(capd[12 +: 2]),
        .i_i2c_n(capd[16 +: 2]),
        .o_cfg(dec)
    );

    // ==========
    // register file
    always_comb
    begin
        wr_mgmt = i_reg_req.wr && (i_reg_req.addr == strap_cfg_pkg::MGMT_CTRL_OFS);
        wr_part = i_reg_req.wr && (i_reg_req.addr == strap_cfg_pkg::PART_EN_OFS);
        wr_rel = i_reg_req.wr && (i_reg_req.addr == strap_cfg_pkg::CFG_REL_OFS);
        // only the two management ports or the I2C agent may promote
        promote_ok = red_en_r && ((i_reg_req.src == strap_cfg_pkg::SRC_I2C)
                     || ((i_reg_req.src == strap_cfg_pkg::SRC_SW)
                     && ((i_reg_req.port == act_r) || (i_reg_req.port == red_r))));
        cfg_nxt = cfg_r;
        act_nxt = act_r;
        act_en_nxt = act_en_r;
        red_nxt = red_r;
        red_en_nxt = red_en_r;
        part_nxt = part_r;
        init_nxt = init_r;
        valid_nxt = valid_r;
        if (cap_pulse)
        begin
            cfg_nxt = dec;
            act_nxt = dec.port;
            act_en_nxt = dec.partition_count_strap && (dec.mgmt_strap != strap_cfg_pkg::TRIT_HIGH);
            part_nxt = dec.part_bits;
            valid_nxt = 1'b1;
        end
        else
        begin
            if (wr_mgmt)
            begin
                act_nxt = i_reg_req.wdata[strap_cfg_pkg::MGMT_ACT_LSB +: 5];
                act_en_nxt = i_reg_req.wdata[strap_cfg_pkg::MGMT_ACT_EN_BIT];
                red_nxt = i_reg_req.wdata[strap_cfg_pkg::MGMT_RED_LSB +: 5];
                red_en_nxt = i_reg_req.wdata[strap_cfg_pkg::MGMT_RED_EN_BIT];
                if (i_reg_req.wdata[strap_cfg_pkg::MGMT_PROMOTE_BIT] && promote_ok)
                begin
                    act_nxt = red_r;
                    red_nxt = act_r;
                    act_en_nxt = 1'b1;
                end
            end
            if (wr_part)
                part_nxt = i_reg_req.wdata[strap_cfg_pkg::PART_EN_LSB +: 6];
            // I2C may release only when its own strap asked for the hold
            if (wr_rel && i_reg_req.wdata[strap_cfg_pkg::INIT_CFG_BIT]
                && ((i_reg_req.src != strap_cfg_pkg::SRC_I2C) || cfg_r.i2c_hold))
                init_nxt = 1'b1;
        end
        rdata_nxt = rdata_r;
        ack_nxt = i_reg_req.wr || i_reg_req.rd;
        if (i_reg_req.rd)
        begin
            rdata_nxt = 32'h0;
            unique case (i_reg_req.addr)
                strap_cfg_pkg::MGMT_CTRL_OFS:
                begin
                    rdata_nxt[strap_cfg_pkg::MGMT_ACT_LSB +: 5] = act_r;
                    rdata_nxt[strap_cfg_pkg::MGMT_ACT_EN_BIT] = act_en_r;
                    rdata_nxt[strap_cfg_pkg::MGMT_RED_LSB +: 5] = red_r;
                    rdata_nxt[strap_cfg_pkg::MGMT_RED_EN_BIT] = red_en_r;
                end
                strap_cfg_pkg::PART_EN_OFS: rdata_nxt[strap_cfg_pkg::PART_EN_LSB +: 6] = part_r;
                strap_cfg_pkg::CFG_REL_OFS: rdata_nxt[strap_cfg_pkg::INIT_CFG_BIT] = init_r;
                strap_cfg_pkg::STRAP_STAT_OFS:
                begin
                    rdata_nxt[strap_cfg_pkg::PART_STAT_LSB +: 3] = {1'b0, cfg_r.part_trit};
                    rdata_nxt[strap_cfg_pkg::MODE_STAT_LSB +: 5] = cfg_r.mode;
                end
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cfg_r <= '0;
            act_r <= strap_cfg_pkg::PORT_RST;
            act_en_r <= strap_cfg_pkg::MGMT_EN_RST;
            red_r <= strap_cfg_pkg::PORT_RST;
            red_en_r <= 1'b0;
            part_r <= strap_cfg_pkg::PART_EN_RST;
            init_r <= 1'b0;
            valid_r <= 1'b0;
            rdata_r <= 32'h0;
            ack_r <= 1'b0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            act_r <= act_nxt;
            act_en_r <= act_en_nxt;
            red_r <= red_nxt;
            red_en_r <= red_en_nxt;
            part_r <= part_nxt;
            init_r <= init_nxt;
            valid_r <= valid_nxt;
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    // ==========
    // link release sequencing
    always_comb
    begin
        hold_mgmt = cfg_r.partition_count_strap && (cfg_r.mgmt_strap == strap_cfg_pkg::TRIT_LOW);
        st_nxt = st_r;
        unique case (st_r)
            ST_SAMPLE: if (valid_r) st_nxt = ST_EEPROM;
            ST_EEPROM:
                if (i_eeprom_done)
                    st_nxt = (cfg_r.i2c_hold || hold_mgmt) ? ST_HOLD : ST_RUN;
            ST_HOLD: if (init_r) st_nxt = ST_RUN;
            ST_RUN: st_nxt = ST_RUN;
        endcase
        link_nxt = '0;
        if (st_r == ST_RUN)
            link_nxt = '1;
        else if ((st_r == ST_HOLD) && !cfg_r.i2c_hold && hold_mgmt && act_en_r)
            link_nxt = port_onehot(act_r);
        // the shared pin only means power good outside partition mode
        pg_nxt = !cfg_r.partition_count_strap && (live[12 +: 2] == strap_cfg_pkg::TRIT_HIGH);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            st_r <= ST_SAMPLE;
            link_r <= '0;
            pg_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            link_r <= link_nxt;
            pg_r <= pg_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_reg_ack = ack_r;
    assign o_link_train_en = link_r;
    assign o_partition_enable_bits = part_r;
    assign o_partition_count_strap = cfg_r.partition_count_strap;
    assign o_slot_a_power_good = pg_r;
    assign o_mgmt_port = act_r;

    // ==========
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_capture;
        cap_pulse;
    endsequence

    sequence s_released;
        (st_r == ST_HOLD) && init_r ##1 (st_r == ST_RUN);
    endsequence

    a_mgmt_port_load: assert property (s_capture |=> (act_r == $past(dec.port)))
        else $error("active management port not loaded from straps");
    a_mgmt_enable_load: assert property (s_capture |=> (act_en_r ==
        ($past(dec.partition_count_strap) && ($past(dec.mgmt_strap) != strap_cfg_pkg::TRIT_HIGH))))
        else $error("management port enable wrong after capture");
    a_partition_load: assert property (s_capture |=> (part_r == $past(dec.part_bits)))
        else $error("partition enables not loaded from straps");
    a_hold_only_mgmt: assert property ((st_r == ST_HOLD) && !cfg_r.i2c_hold && hold_mgmt && act_en_r
        |=> (o_link_train_en == port_onehot($past(act_r))) || (st_r == ST_RUN))
        else $error("link other than management port trains during hold");
    a_release_links: assert property (s_released |=> (o_link_train_en == '1))
        else $error("links not released after initiate");
    a_float_no_hold: assert property ((st_r == ST_EEPROM) && i_eeprom_done && !cfg_r.i2c_hold
        && (cfg_r.mgmt_strap == strap_cfg_pkg::TRIT_FLOAT) |=> (st_r == ST_RUN) ##1 (o_link_train_en == '1))
        else $error("floating strap did not start all links");
    a_i2c_hold: assert property (cfg_r.i2c_hold && (st_r != ST_RUN) |=> (o_link_train_en == '0))
        else $error("link trains during I2C hold");
    a_i2c_refused: assert property (wr_rel && !cap_pulse && (i_reg_req.src == strap_cfg_pkg::SRC_I2C)
        && !cfg_r.i2c_hold && !init_r |=> !init_r)
        else $error("I2C set initiate without its strap");
    a_promote: assert property (wr_mgmt && !cap_pulse && i_reg_req.wdata[strap_cfg_pkg::MGMT_PROMOTE_BIT]
        && promote_ok |=> (act_r == $past(red_r)) && (red_r == $past(act_r)))
        else $error("redundant port not promoted");
    a_slot_pg_base: assert property (cfg_r.partition_count_strap |=> !o_slot_a_power_good)
        else $error("power good shown in partition mode");
    a_status_stable: assert property (valid_r && !cap_pulse |=> $stable(cfg_r))
        else $error("strap status changed without reset");

    // nothing may train while straps settle or the loader still runs
    a_no_early_link: assert property ((st_r == ST_SAMPLE) || (st_r == ST_EEPROM)
        |=> (o_link_train_en == '0))
        else $error("link trains before loader finished");
    a_part_write: assert property (wr_part && !cap_pulse
        |=> (part_r == $past(i_reg_req.wdata[strap_cfg_pkg::PART_EN_LSB +: 6])))
        else $error("partition enables not taken from write");
    a_reg_ack: assert property ((i_reg_req.wr || i_reg_req.rd) |=> o_reg_ack)
        else $error("register request not acknowledged");
endmodule

/* common/strap_cfg_pkg.sv */
// constants and types shared by the partition strap configuration block
package strap_cfg_pkg;
    // ==========
    // tri-state strap codes
    typedef logic [1:0] trit_t;
    localparam trit_t TRIT_LOW = 2'h0;
    localparam trit_t TRIT_FLOAT = 2'h1;
    localparam trit_t TRIT_HIGH = 2'h2;

    // ==========
    // register offsets
    localparam logic [11:0] MGMT_CTRL_OFS = 12'h354;
    localparam logic [11:0] PART_EN_OFS = 12'h358;
    localparam logic [11:0] CFG_REL_OFS = 12'h3ac;
    localparam logic [11:0] STRAP_STAT_OFS = 12'h46c;

    // ==========
    // field positions
    localparam int MGMT_ACT_LSB = 0;
    localparam int MGMT_ACT_EN_BIT = 5;
    localparam int MGMT_RED_LSB = 8;
    localparam int MGMT_RED_EN_BIT = 13;
    localparam int MGMT_PROMOTE_BIT = 14;
    localparam int INIT_CFG_BIT = 0;
    localparam int PART_EN_LSB = 0;
    localparam int PART_STAT_LSB = 13;
    localparam int MODE_STAT_LSB = 24;

    // ==========
    // values after reset
    localparam logic [4:0] PORT_RST = 5'h00;
    localparam logic MGMT_EN_RST = 1'b0;
    localparam logic [5:0] PART_EN_RST = 6'h01;
    localparam logic [4:0] MODE_RST = 5'h00;

    // ==========
    // function select ranges and partition counts
    localparam logic [4:0] MODE_VS_LO = 5'h04;
    localparam logic [4:0] MODE_VS_BIG = 5'h08;
    localparam logic [4:0] MODE_VS_HI = 5'h0b;
    localparam logic [4:0] PORT_MAX = 5'h13;
    localparam logic [2:0] PART_BASE_SMALL = 3'h1;
    localparam logic [2:0] PART_BASE_BIG = 3'h4;

    // ==========
    // strap sampling counts
    localparam int SYNC_STAGES = 3;
    localparam logic [2:0] SETTLE_CYCLES = 3'h4;

    // ==========
    // carriers
    typedef enum logic [1:0] {SRC_SW, SRC_EEPROM, SRC_I2C} src_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [31:0] wdata;
        src_e src;
        logic [4:0] port;
    } reg_req_s;

    typedef struct packed {
        logic partition_count_strap;
        trit_t mgmt_strap;
        logic i2c_hold;
        logic [4:0] port;
        logic port_rsvd;
        logic [5:0] part_bits;
        trit_t part_trit;
        logic [4:0] mode;
    } strap_cfg_s;

    // ==========
    // ternary value of three straps, msb first; an illegal code counts as floating
    function automatic int trit_digit(input trit_t t);
        trit_digit = (t == TRIT_LOW) ? 0 : ((t == TRIT_HIGH) ? 2 : 1);
    endfunction

    function automatic logic [4:0] trit_val(input trit_t t2, input trit_t t1, input trit_t t0);
        trit_val = 5'(9 * trit_digit(t2) + 3 * trit_digit(t1) + trit_digit(t0));
    endfunction
endpackage

/* design/tristate_strap_sampler.sv */
// three-flop synchroniser and reset-time capture for tri-state straps
`timescale 1ns/1ns
module tristate_strap_sampler #(
    parameter int N = 9
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [2*N-1:0] i_pin,
    output logic [2*N-1:0] o_live,
    output logic [2*N-1:0] o_captured,
    output logic o_capture_pulse
);
    logic [2*N-1:0] s1_r, s2_r, s3_r;
    logic [2*N-1:0] live_r, live_nxt, cap_r, cap_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt, pulse_r, pulse_nxt;

    // ==========
    // capture once the chain has settled and the last two stages agree
    always_comb
    begin
        live_nxt = (s2_r == s3_r) ? s3_r : live_r;
        cap_nxt = cap_r;
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        pulse_nxt = 1'b0;
        if (!done_r)
        begin
            if (cnt_r != strap_cfg_pkg::SETTLE_CYCLES)
                cnt_nxt = cnt_r + 3'h1;
            else if (s2_r == s3_r)
            begin
                cap_nxt = s3_r;
                done_nxt = 1'b1;
                pulse_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            live_r <= '0;
            cap_r <= '0;
            cnt_r <= 3'h0;
            done_r <= 1'b0;
            pulse_r <= 1'b0;
        end
        else
        begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            live_r <= live_nxt;
            cap_r <= cap_nxt;
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    assign o_live = live_r;
    assign o_captured = cap_r;
    assign o_capture_pulse = pulse_r;
endmodule

/* design/partition_strap_decoder.sv */
// decodes captured straps into mode, management port and partition enables
`timescale 1ns/1ns
module partition_strap_decoder (
    input wire strap_cfg_pkg::trit_t i_fsel [3],
    input wire strap_cfg_pkg::trit_t i_usel [3],
    input wire strap_cfg_pkg::trit_t i_mgmt,
    input wire strap_cfg_pkg::trit_t i_part,
    input wire strap_cfg_pkg::trit_t i_i2c_n,
    output strap_cfg_pkg::strap_cfg_s o_cfg
);
    logic [4:0] mode, port;
    logic [2:0] cnt;

    always_comb
    begin
        mode = strap_cfg_pkg::trit_val(i_fsel[2], i_fsel[1], i_fsel[0]);
        port = strap_cfg_pkg::trit_val(i_usel[2], i_usel[1], i_usel[0]);
        cnt = ((mode >= strap_cfg_pkg::MODE_VS_BIG) ? strap_cfg_pkg::PART_BASE_BIG
              : strap_cfg_pkg::PART_BASE_SMALL) + 3'(strap_cfg_pkg::trit_digit(i_part));
        o_cfg.mode = mode;
        o_cfg.partition_count_strap = (mode >= strap_cfg_pkg::MODE_VS_LO) && (mode <= strap_cfg_pkg::MODE_VS_HI);
        // 4..7, 12..15 and above 19 have no port behind them
        o_cfg.port_rsvd = port[2] || (port > strap_cfg_pkg::PORT_MAX);
        o_cfg.port = o_cfg.port_rsvd ? strap_cfg_pkg::PORT_RST : port;
        o_cfg.mgmt_strap = i_mgmt;
        o_cfg.i2c_hold = (i_i2c_n == strap_cfg_pkg::TRIT_LOW);
        o_cfg.part_trit = i_part;
        o_cfg.part_bits = o_cfg.partition_count_strap ? 6'((7'h1 << cnt) - 7'h1) : strap_cfg_pkg::PART_EN_RST;
    end
endmodule

/* verification/strap_board_model.sv */
// board side model: eeprom loader completion and partition reset level
`timescale 1ns/1ns
module strap_board_model #(
    parameter int LOAD_CYCLES = 12
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_stall,
    output logic o_eeprom_done,
    output logic o_partition_reset_in_n
);
    // ==========
    // load timer
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (cnt_r != 8'(LOAD_CYCLES))
        begin
            cnt_nxt = cnt_r + 8'h01;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt_r <= 8'h00;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end
    // stall models a slow loader, so the wait before the load finishes can be watched
    assign o_eeprom_done = (cnt_r == 8'(LOAD_CYCLES)) && !i_stall;
    // port 0 must stay reachable during setup
    assign o_partition_reset_in_n = 1'b1;
endmodule

/* verification/tb_switch_partition_strap_config.sv */
// self-checking bench for the partition strap configuration block
`timescale 1ns/1ns
module tb_switch_partition_strap_config;
    logic clk;
    logic nrst;
    logic stall;
    strap_cfg_pkg::trit_t fsel [3];
    strap_cfg_pkg::trit_t usel [3];
    strap_cfg_pkg::trit_t mgmt;
    strap_cfg_pkg::trit_t part;
    strap_cfg_pkg::trit_t i2c_n;
    strap_cfg_pkg::reg_req_s req;
    logic eeprom_done;
    logic prst_n;
    logic [31:0] rdata;
    logic ack;
    logic [19:0] link;
    logic [5:0] pbits;
    logic vsm;
    logic spg;
    logic [4:0] mport;
    int num_errors = 0;
    int compares = 0;

    // ==========
    // design and partner
    switch_partition_strap_config #(.NUM_PORTS(20)) DUT (
        .i_sys_clk(clk), .i_nrst(nrst), .i_function_select_strap(fsel),
        .i_upstream_select_strap(usel), .i_management_enable_strap(mgmt),
        .i_partition_count_strap(part), .i_i2c_cfg_strap_n(i2c_n),
        .i_eeprom_done(eeprom_done), .i_reg_req(req), .o_reg_rdata(rdata), .o_reg_ack(ack),
        .o_link_train_en(link), .o_partition_enable_bits(pbits), .o_partition_count_strap(vsm),
        .o_slot_a_power_good(spg), .o_mgmt_port(mport));
    strap_board_model #(.LOAD_CYCLES(12)) board (
        .i_sys_clk(clk), .i_nrst(nrst), .i_stall(stall),
        .o_eeprom_done(eeprom_done), .o_partition_reset_in_n(prst_n));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ==========
    // helpers
    task automatic complete_run();
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // strap digits: 0 low, 1 floating, 2 high; straps stay put through capture
    task automatic restart(input int fs, input int us, input int m, input int p, input int i2, input logic st);
        @(negedge clk);
        nrst = 1'b0;
        stall = st;
        fsel[2] = 2'(fs / 9);
        fsel[1] = 2'((fs / 3) % 3);
        fsel[0] = 2'(fs % 3);
        usel[2] = 2'(us / 9);
        usel[1] = 2'((us / 3) % 3);
        usel[0] = 2'(us % 3);
        mgmt = 2'(m);
        part = 2'(p);
        i2c_n = 2'(i2);
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        repeat (10) @(negedge clk);
    endtask

    task automatic reg_op(input logic w, input logic [11:0] a, input logic [31:0] d,
                          input strap_cfg_pkg::src_e s, input logic [4:0] p, output logic [31:0] q);
        @(negedge clk);
        req.wr = w;
        req.rd = !w;
        req.addr = a;
        req.wdata = d;
        req.src = s;
        req.port = p;
        @(negedge clk);
        req.wr = 1'b0;
        req.rd = 1'b0;
        chk({31'h0, ack}, 32'h1);
        q = rdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input strap_cfg_pkg::src_e s, input logic [4:0] p);
        logic [31:0] q;
        reg_op(1'b1, a, d, s, p, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        reg_op(1'b0, a, 32'h0, strap_cfg_pkg::SRC_SW, 5'h00, q);
        chk(q, exp);
    endtask

    // which: 0 link permits, 1 slot power good
    task automatic wait_for(input int which, input logic [19:0] exp);
        logic [19:0] cur;
        cur = which ? {19'h0, spg} : link;
        for (int n = 0; cur !== exp; n++)
        begin
            if (n == 30)
            begin
                num_errors++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, cur, exp);
                complete_run();
            end
            @(negedge clk);
            cur = which ? {19'h0, spg} : link;
        end
        compares++;
    endtask

    // ==========
    // scenarios
    task automatic s_counts();
        int md [4] = '{4, 7, 8, 11};
        int n;
        for (int i = 0; i < 4; i++)
        begin
            for (int j = 0; j < 3; j++)
            begin
                restart(md[i], 0, 2, j, 2, 1'b0);
                n = (md[i] >= 8 ? 4 : 1) + j;
                chk({31'h0, vsm}, 32'h1);
                chk({26'h0, pbits}, 32'((1 << n) - 1));
                rd(strap_cfg_pkg::PART_EN_OFS, 32'((1 << n) - 1));
                rd(strap_cfg_pkg::STRAP_STAT_OFS, 32'(md[i] << 24) | 32'(j << 13));
            end
        end
    endtask

    task automatic s_base();
        restart(0, 0, 2, 2, 2, 1'b0);
        chk({25'h0, vsm, pbits}, 32'h1);
        wait_for(1, 20'h1);
        part = 2'h0;
        wait_for(1, 20'h0);
        rd(strap_cfg_pkg::STRAP_STAT_OFS, 32'h4000);
        restart(4, 0, 2, 2, 2, 1'b0);
        wait_for(1, 20'h0);
        // factory codes above the partition range fall back to base mode
        restart(12, 0, 2, 2, 2, 1'b0);
        chk({25'h0, vsm, pbits}, 32'h1);
        rd(strap_cfg_pkg::STRAP_STAT_OFS, 32'h0c004000);
    endtask

    task automatic s_mgmt();
        int us [14] = '{0, 1, 2, 3, 8, 9, 10, 11, 16, 17, 18, 19, 4, 26};
        logic [4:0] ex;
        for (int i = 0; i < 14; i++)
        begin
            restart(4, us[i], 0, 0, 2, 1'b1);
            ex = (i < 12) ? 5'(us[i]) : 5'h00;
            chk({27'h0, mport}, {27'h0, ex});
            rd(strap_cfg_pkg::MGMT_CTRL_OFS, {26'h0, 1'b1, ex});
        end
        restart(4, 3, 2, 0, 2, 1'b1);
        rd(strap_cfg_pkg::MGMT_CTRL_OFS, 32'h3);
    endtask

    task automatic s_hold();
        restart(4, 2, 0, 0, 2, 1'b1);
        chk({12'h0, link}, 32'h0);
        chk({31'h0, prst_n}, 32'h1);
        stall = 1'b0;
        wait_for(0, 20'h4);
        wr(strap_cfg_pkg::CFG_REL_OFS, 32'h1, strap_cfg_pkg::SRC_I2C, 5'h00);
        repeat (3) @(negedge clk);
        chk({12'h0, link}, 32'h4);
        wr(strap_cfg_pkg::CFG_REL_OFS, 32'h1, strap_cfg_pkg::SRC_SW, 5'h02);
        wait_for(0, 20'hfffff);
        restart(4, 2, 1, 0, 2, 1'b0);
        wait_for(0, 20'hfffff);
        restart(4, 2, 0, 0, 0, 1'b0);
        repeat (6) @(negedge clk);
        chk({12'h0, link}, 32'h0);
        wr(strap_cfg_pkg::CFG_REL_OFS, 32'h1, strap_cfg_pkg::SRC_I2C, 5'h00);
        wait_for(0, 20'hfffff);
    endtask

    task automatic s_promote();
        restart(4, 1, 0, 0, 2, 1'b0);
        wr(strap_cfg_pkg::MGMT_CTRL_OFS, 32'h2321, strap_cfg_pkg::SRC_SW, 5'h01);
        rd(strap_cfg_pkg::MGMT_CTRL_OFS, 32'h2321);
        wr(strap_cfg_pkg::MGMT_CTRL_OFS, 32'h6321, strap_cfg_pkg::SRC_SW, 5'h05);
        rd(strap_cfg_pkg::MGMT_CTRL_OFS, 32'h2321);
        wr(strap_cfg_pkg::MGMT_CTRL_OFS, 32'h6321, strap_cfg_pkg::SRC_I2C, 5'h00);
        rd(strap_cfg_pkg::MGMT_CTRL_OFS, 32'h2123);
        chk({27'h0, mport}, 32'h3);
        wr(strap_cfg_pkg::MGMT_CTRL_OFS, 32'h6123, strap_cfg_pkg::SRC_SW, 5'h03);
        rd(strap_cfg_pkg::MGMT_CTRL_OFS, 32'h2321);
        wr(strap_cfg_pkg::PART_EN_OFS, 32'h2a, strap_cfg_pkg::SRC_EEPROM, 5'h00);
        rd(strap_cfg_pkg::PART_EN_OFS, 32'h2a);
        wr(strap_cfg_pkg::STRAP_STAT_OFS, 32'hffffffff, strap_cfg_pkg::SRC_SW, 5'h01);
        rd(strap_cfg_pkg::STRAP_STAT_OFS, 32'h04000000);
        rd(12'h100, 32'h0);
        chk({26'h0, pbits}, 32'h2a);
    endtask

    // ==========
    // main sequence and hang guard
    initial
    begin
        nrst = 1'b0;
        stall = 1'b1;
        req = '0;
        fsel = '{2'h0, 2'h0, 2'h0};
        usel = '{2'h0, 2'h0, 2'h0};
        mgmt = 2'h2;
        part = 2'h0;
        i2c_n = 2'h2;
        s_counts();
        s_base();
        s_mgmt();
        s_hold();
        s_promote();
        complete_run();
    end

    initial
    begin
        // well above the normal run, well below the cycle budget
        #3000000;
        num_errors++;
        complete_run();
    end
endmodule
